//--- rtl/ifd_pkg.sv
package ifd_pkg;

    // ------------------------------------------------------------
    // field positions as vector bits (word bit 0 is the msb)
    // ------------------------------------------------------------
    localparam int OPC_LSB = 26;
    localparam int OPC_W = 6;
    localparam int GPR_W = 5;
    localparam int GA_LSB = 16;
    localparam int GB_LSB = 11;
    localparam int NIB_LSB = 12;
    localparam int NIB_W = 4;
    localparam int GRP_LSB = 23;
    localparam int GRP_W = 3;
    localparam int VEC_LSB = 5;
    localparam int VEC_W = 7;
    localparam int ABS_BIT = 1;
    localparam int OFS_LSB = 2;
    localparam int OFS_W = 24;
    localparam int SAVE_BIT = 0;
    localparam int OE_BIT = 10;
    localparam int IDX_W = 5;
    localparam int MSTART_LSB = 6;
    localparam int MSTOP_LSB = 1;
    localparam int CNT_LSB = 11;
    localparam int REC_BIT = 0;

    // ------------------------------------------------------------
    // constants and reset values
    // ------------------------------------------------------------
    localparam logic [31:0] SC_ABS_ADDR = 32'h0000_1FE0;
    localparam logic [18:0] SC_HIGH = 19'h0_0000;
    localparam logic SC_LEAD = 1'h1;
    localparam logic [4:0] SC_PAD = 5'h00;
    localparam logic [31:0] NEXT_STEP = 32'h0000_0004;
    localparam logic [31:0] LINK_RST = 32'h0000_0000;
    localparam logic [31:0] FLAGS_RST = 32'h0000_0000;
    localparam logic [31:0] FSTAT_RST = 32'h0000_0000;
    localparam logic WRAP_RST = 1'h0;

    // instruction class, supplied by the fetch predecoder
    typedef enum logic [2:0] {
        IFD_CLS_OTHER,
        IFD_CLS_BRANCH,
        IFD_CLS_SYSCALL,
        IFD_CLS_FIXED,
        IFD_CLS_EXT_ARITH,
        IFD_CLS_FLOAT,
        IFD_CLS_STRING_IMM,
        IFD_CLS_FSTAT_IMM
    } ifd_class_t;

endpackage

//--- rtl/ifd_field_if.sv
`timescale 1ns/1ps
`default_nettype none

// fields handed to the mask and target generators
interface ifd_field_if;
    logic [4:0] mask_start;
    logic [4:0] mask_stop;
    logic [31:0] mask;
    logic [23:0] offset;
    logic [6:0] vec_idx;
    logic abs_vec;
    logic [31:0] disp;
    logic [31:0] sc_addr;

    modport mask_mp(input mask_start, input mask_stop, output mask);
    modport tgt_mp(input offset, input vec_idx, input abs_vec, output disp, output sc_addr);
    modport use_mp(
        output mask_start, output mask_stop, output offset,
        output vec_idx, output abs_vec,
        input mask, input disp, input sc_addr
    );
endinterface

`default_nettype wire

//--- rtl/ifd_mask_gen.sv
`timescale 1ns/1ps
`default_nettype none

module ifd_mask_gen
    import ifd_pkg::*;
(
    ifd_field_if.mask_mp fb
);

    // ------------------------------------------------------------
    // rotate mask, index k counts from the msb
    // ------------------------------------------------------------
    logic [5:0] stop_p1;
    logic [5:0] start_x;

    assign stop_p1 = {1'b0, fb.mask_stop} + 6'h01;
    assign start_x = {1'b0, fb.mask_start};

    // 6-bit compare so stop = 31 gives 32, not a wrap to 0
    always_comb begin
        for (int k = 0; k < 32; k++) begin
            if (start_x < stop_p1) begin
                fb.mask[31 - k] = (6'(k) >= start_x) && (6'(k) < stop_p1);
            end else if (start_x == stop_p1) begin
                fb.mask[31 - k] = 1'b1;
            end else begin
                fb.mask[31 - k] = (6'(k) >= start_x) || (6'(k) < stop_p1);
            end
        end
    end

endmodule

`default_nettype wire

//--- rtl/ifd_target_gen.sv
`timescale 1ns/1ps
`default_nettype none

module ifd_target_gen
    import ifd_pkg::*;
(
    ifd_field_if.tgt_mp fb
);

    // ------------------------------------------------------------
    // branch displacement and system-call vector
    // ------------------------------------------------------------
    // word-aligned offset, sign carried into the top six bits
    assign fb.disp = {{6{fb.offset[23]}}, fb.offset, 2'b00};

    // absolute flag overrides the index-derived vector
    assign fb.sc_addr = fb.abs_vec ? SC_ABS_ADDR
        : {SC_HIGH, SC_LEAD, fb.vec_idx, SC_PAD};

endmodule

`default_nettype wire

//--- rtl/ifd_decoder.sv
//
// Contract
// - primary opcode is word bits 0 to 5.
// - overflow enable on extended arithmetic updates wrap and sticky flags.
// - bits 11-15 and 16-20 select general registers.
// - bits 16-19 immediate written into one float status nibble.
// - system call, absolute flag clear: address is 1, index, five zeros.
// - system call, absolute flag set: address is 1FE0 hex.
// - bits 6-29 shifted left two and sign-extended form displacement.
// - save-return set on branch or call loads link with next address.
// - mask start from bits 21-25, stop from bits 26-30.
// - start below stop plus one: ones from start through stop.
// - start equal to stop plus one: all ones.
// - start above stop plus one: zeros between, ones elsewhere.
// - bits 16-20 give byte count of immediate string transfer.
// - record flag set updates condition flags, clear leaves them.
// - fixed-point record sets condition bits 0-2 from signed result, bit 3 from sticky overflow.
// - float record copies four exception indications to bits 4-7.
//
`timescale 1ns/1ps
`default_nettype none

module ifd_decoder
    import ifd_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic fetch_valid,
    input wire logic [31:0] fetch_word,
    input wire logic [31:0] fetch_addr,
    input wire ifd_class_t fetch_class,
    input wire logic ex_valid,
    input wire logic [31:0] ex_result,
    input wire logic ex_overflow,
    input wire logic [3:0] ex_fp_flags,
    output logic dec_valid_q,
    output ifd_class_t dec_class_q,
    output logic [5:0] opcode_q,
    output logic [4:0] gpr_a_q,
    output logic [4:0] gpr_b_q,
    output logic [4:0] byte_count_q,
    output logic record_q,
    output logic ovf_en_q,
    output logic [31:0] rot_mask_q,
    output logic [31:0] branch_disp_q,
    output logic [31:0] sc_addr_q,
    output logic [31:0] link_q,
    output logic [31:0] cond_q,
    output logic wrap_q,
    output logic sticky_q,
    output logic [31:0] fstat_q
);

    // ------------------------------------------------------------
    // field extraction
    // ------------------------------------------------------------
    // one shared shifter, so field positions live only in the package
    function automatic logic [31:0] fld(
        input logic [31:0] w,
        input int lsb,
        input int width
    );
        logic [31:0] m;
        m = (32'h0000_0001 << width) - 32'h0000_0001;
        return (w >> lsb) & m;
    endfunction

    ifd_field_if fb ();

    logic links;
    logic [2:0] grp;
    logic [3:0] nib;
    logic sticky_d;
    logic fixed_rec;
    logic float_rec;
    logic ovf_upd;

    // generators see the word still at the decode register input
    assign fb.mask_start = 5'(fld(fetch_word, MSTART_LSB, IDX_W));
    assign fb.mask_stop = 5'(fld(fetch_word, MSTOP_LSB, IDX_W));
    assign fb.offset = 24'(fld(fetch_word, OFS_LSB, OFS_W));
    assign fb.vec_idx = 7'(fld(fetch_word, VEC_LSB, VEC_W));
    assign fb.abs_vec = fetch_word[ABS_BIT];

    ifd_mask_gen u_mask (
        .fb(fb.mask_mp)
    );

    ifd_target_gen u_tgt (
        .fb(fb.tgt_mp)
    );

    // call or branch asking for a return address
    assign links = fetch_valid && fetch_word[SAVE_BIT]
        && (fetch_class == IFD_CLS_BRANCH || fetch_class == IFD_CLS_SYSCALL);
    assign grp = 3'(fld(fetch_word, GRP_LSB, GRP_W));
    assign nib = 4'(fld(fetch_word, NIB_LSB, NIB_W));

    // ------------------------------------------------------------
    // decode register
    // ------------------------------------------------------------
    // every field is latched so execution units see it one edge later
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            dec_valid_q <= 1'b0;
            dec_class_q <= IFD_CLS_OTHER;
            opcode_q <= 6'h00;
            gpr_a_q <= 5'h00;
            gpr_b_q <= 5'h00;
            byte_count_q <= 5'h00;
            record_q <= 1'b0;
            ovf_en_q <= 1'b0;
            rot_mask_q <= 32'h0000_0000;
            branch_disp_q <= 32'h0000_0000;
            sc_addr_q <= 32'h0000_0000;
        end else begin
            dec_valid_q <= fetch_valid;
            if (fetch_valid) begin
                dec_class_q <= fetch_class;
                opcode_q <= 6'(fld(fetch_word, OPC_LSB, OPC_W));
                gpr_a_q <= 5'(fld(fetch_word, GA_LSB, GPR_W));
                gpr_b_q <= 5'(fld(fetch_word, GB_LSB, GPR_W));
                byte_count_q <= 5'(fld(fetch_word, CNT_LSB, GPR_W));
                record_q <= fetch_word[REC_BIT];
                ovf_en_q <= fetch_word[OE_BIT];
                rot_mask_q <= fb.mask;
                branch_disp_q <= fb.disp;
                sc_addr_q <= fb.sc_addr;
            end
        end
    end

    // ------------------------------------------------------------
    // link register
    // ------------------------------------------------------------
    // a flag-clear branch or call leaves the old link intact
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            link_q <= LINK_RST;
        end else if (links) begin
            link_q <= fetch_addr + NEXT_STEP;
        end
    end

    // ------------------------------------------------------------
    // float status immediate
    // ------------------------------------------------------------
    // group 0 is the most significant nibble, hence the inverted index
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            fstat_q <= FSTAT_RST;
        end else if (fetch_valid && fetch_class == IFD_CLS_FSTAT_IMM) begin
            fstat_q[{~grp, 2'b00} +: 4] <= nib;
        end
    end

    // ------------------------------------------------------------
    // result-side flags
    // ------------------------------------------------------------
    // results always belong to the instruction held in the decode register
    assign ovf_upd = ex_valid && ovf_en_q && dec_class_q == IFD_CLS_EXT_ARITH;
    assign fixed_rec = ex_valid && record_q
        && (dec_class_q == IFD_CLS_FIXED || dec_class_q == IFD_CLS_EXT_ARITH);
    assign float_rec = ex_valid && record_q && dec_class_q == IFD_CLS_FLOAT;
    // summary bit copied into the flags must include this very overflow
    assign sticky_d = ovf_upd ? (sticky_q | ex_overflow) : sticky_q;

    // overflow pair, sticky only ever sets until reset
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            wrap_q <= WRAP_RST;
            sticky_q <= WRAP_RST;
        end else if (ovf_upd) begin
            wrap_q <= ex_overflow;
            sticky_q <= sticky_d;
        end
    end

    // condition flags, written only on a recording result
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            cond_q <= FLAGS_RST;
        end else if (fixed_rec) begin
            cond_q[31] <= ex_result[31];
            cond_q[30] <= !ex_result[31] && (ex_result != 32'h0000_0000);
            cond_q[29] <= (ex_result == 32'h0000_0000);
            cond_q[28] <= sticky_d;
        end else if (float_rec) begin
            cond_q[27:24] <= ex_fp_flags;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    // every check samples on the core clock and sleeps through reset
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    chk_opcode_take: assert property (
        fetch_valid |=> opcode_q == $past(fetch_word[31:26]) && dec_valid_q
    ) else $error("opcode not taken from top six bits");

    chk_gpr_select: assert property (
        fetch_valid |=> gpr_a_q == $past(fetch_word[20:16])
            && gpr_b_q == $past(fetch_word[15:11])
    ) else $error("register selectors wrong");

    chk_nibble_write: assert property (
        fetch_valid && fetch_class == IFD_CLS_FSTAT_IMM && fetch_word[25:23] == 3'h0
        |=> fstat_q[31:28] == $past(fetch_word[15:12])
    ) else $error("float status nibble not written");

    chk_sc_vector: assert property (
        fetch_valid && !fetch_word[1]
        |=> sc_addr_q == {19'h0_0000, 1'b1, $past(fetch_word[11:5]), 5'h00}
    ) else $error("indexed call vector wrong");

    chk_sc_absolute: assert property (
        fetch_valid && fetch_word[1] |=> sc_addr_q == 32'h0000_1FE0
    ) else $error("absolute call vector wrong");

    chk_disp_sext: assert property (
        fetch_valid |=> branch_disp_q[1:0] == 2'b00
            && branch_disp_q[31:25] == {7{$past(fetch_word[25])}}
            && branch_disp_q[25:2] == $past(fetch_word[25:2])
    ) else $error("displacement not sign extended");

    chk_link_load: assert property (
        links |=> link_q == $past(fetch_addr) + 32'h0000_0004
    ) else $error("link not loaded with next address");

    chk_link_hold: assert property (
        !links |=> $stable(link_q)
    ) else $error("link changed without save-return");

    chk_mask_contig: assert property (
        fb.mask_start <= fb.mask_stop
        |-> $countones(fb.mask) == 32'(fb.mask_stop) - 32'(fb.mask_start) + 1
            && fb.mask[31 - fb.mask_start]
    ) else $error("contiguous mask wrong");

    chk_mask_full: assert property (
        6'(fb.mask_start) == 6'(fb.mask_stop) + 6'h01 |-> fb.mask == 32'hFFFF_FFFF
    ) else $error("full mask not all ones");

    chk_mask_wrap: assert property (
        6'(fb.mask_start) > 6'(fb.mask_stop) + 6'h01
        |-> $countones(fb.mask) == 32 - (32'(fb.mask_start) - 32'(fb.mask_stop) - 1)
            && !fb.mask[30 - fb.mask_stop]
    ) else $error("wrapped mask wrong");

    chk_mask_fields: assert property (
        fetch_valid |=> rot_mask_q[31 - $past(fetch_word[10:6])]
            || rot_mask_q[31 - $past(fetch_word[5:1])] == 1'b0
    ) else $error("mask start bit clear while stop bit set");

    chk_count_take: assert property (
        fetch_valid |=> byte_count_q == $past(fetch_word[15:11])
    ) else $error("byte count wrong");

    chk_cond_hold: assert property (
        !(ex_valid && record_q) |=> $stable(cond_q)
    ) else $error("condition flags changed without record");

    chk_cond_fixed: assert property (
        fixed_rec |=> cond_q[29] == ($past(ex_result) == 32'h0000_0000)
            && cond_q[31] == $past(ex_result[31]) && cond_q[28] == sticky_q
    ) else $error("fixed-point condition bits wrong");

    chk_cond_greater: assert property (
        fixed_rec |=> cond_q[30] == ($signed($past(ex_result)) > 0)
    ) else $error("greater-than condition bit wrong");

    chk_cond_float: assert property (
        float_rec |=> cond_q[27:24] == $past(ex_fp_flags) && $stable(cond_q[31:28])
    ) else $error("float condition bits wrong");

    chk_wrap_update: assert property (
        ex_valid |=> (wrap_q == $past(ex_overflow)) || !$past(ovf_upd)
            && $stable(wrap_q) && $stable(sticky_q)
    ) else $error("overflow flags wrong");

    chk_sticky_update: assert property (
        ovf_upd && ex_overflow |=> sticky_q && wrap_q
    ) else $error("overflow did not set both flags");

    chk_sticky_keep: assert property (
        sticky_q |=> sticky_q
    ) else $error("sticky overflow fell without reset");

    chk_fields_hold: assert property (
        !fetch_valid |=> !dec_valid_q && $stable(opcode_q) && $stable(rot_mask_q)
            && $stable(sc_addr_q) && $stable(branch_disp_q)
    ) else $error("decoded fields moved without a fetch");

    // covers mark the scenarios the bench must reach
    cov_link_branch: cover property (links && fetch_class == IFD_CLS_BRANCH);
    cov_sc_abs: cover property (fetch_valid && fetch_class == IFD_CLS_SYSCALL && fetch_word[1]);
    cov_mask_wrap: cover property (6'(fb.mask_start) > 6'(fb.mask_stop) + 6'h01);
    cov_float_rec: cover property (float_rec);
    cov_cond_zero: cover property (fixed_rec && ex_result == 32'h0000_0000);

endmodule

`default_nettype wire

//--- tb/ifd_exec_model.sv
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// execution unit model: answers each decode promptly or a cycle late
// ------------------------------------------------------------
module ifd_exec_model (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic dec_valid_q,
    input wire logic slow,
    input wire logic [31:0] res_in,
    input wire logic ovf_in,
    input wire logic [3:0] fp_in,
    output logic ex_valid,
    output logic [31:0] ex_result,
    output logic ex_overflow,
    output logic [3:0] ex_fp_flags
);
    logic late_q;

    // slow answer comes one edge after the decode register fills
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            late_q <= 1'b0;
        end else begin
            late_q <= dec_valid_q & slow;
        end
    end

    // idle lines carry the inverse so a stale value is never trusted
    assign ex_valid = slow ? late_q : dec_valid_q;
    assign ex_result = ex_valid ? res_in : ~res_in;
    assign ex_overflow = ex_valid ? ovf_in : ~ovf_in;
    assign ex_fp_flags = ex_valid ? fp_in : ~fp_in;
endmodule

`default_nettype wire

//--- tb/instruction_field_decoder_test.sv
`timescale 1ns/1ps
`default_nettype none

module instruction_field_decoder_test;
    import ifd_pkg::*;
    logic ref_clk, rst_n, fetch_valid, ex_valid, ex_overflow, slow, ovf_in;
    logic dec_valid_q, record_q, ovf_en_q, wrap_q, sticky_q, m_wrap, m_sticky;
    logic [31:0] fetch_word, fetch_addr, ex_result, res_in, m_link, m_cond, m_fstat;
    logic [31:0] rot_mask_q, branch_disp_q, sc_addr_q, link_q, cond_q, fstat_q;
    logic [3:0] ex_fp_flags, fp_in;
    logic [5:0] opcode_q;
    logic [4:0] gpr_a_q, gpr_b_q, byte_count_q;
    ifd_class_t fetch_class, dec_class_q;
    int err_count = 0;
    int total_checks = 0;

    ifd_decoder i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .fetch_valid(fetch_valid),
        .fetch_word(fetch_word), .fetch_addr(fetch_addr), .fetch_class(fetch_class),
        .ex_valid(ex_valid), .ex_result(ex_result), .ex_overflow(ex_overflow),
        .ex_fp_flags(ex_fp_flags), .dec_valid_q(dec_valid_q), .dec_class_q(dec_class_q),
        .opcode_q(opcode_q), .gpr_a_q(gpr_a_q), .gpr_b_q(gpr_b_q),
        .byte_count_q(byte_count_q), .record_q(record_q), .ovf_en_q(ovf_en_q),
        .rot_mask_q(rot_mask_q), .branch_disp_q(branch_disp_q), .sc_addr_q(sc_addr_q),
        .link_q(link_q), .cond_q(cond_q), .wrap_q(wrap_q), .sticky_q(sticky_q),
        .fstat_q(fstat_q));

    ifd_exec_model i_exec (.ref_clk(ref_clk), .rst_n(rst_n), .dec_valid_q(dec_valid_q),
        .slow(slow), .res_in(res_in), .ovf_in(ovf_in), .fp_in(fp_in), .ex_valid(ex_valid),
        .ex_result(ex_result), .ex_overflow(ex_overflow), .ex_fp_flags(ex_fp_flags));

    // ------------------------------------------------------------
    // checking and closing
    // ------------------------------------------------------------
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            err_count++;
            $display("BAD %s expected %h seen %h", n, e, g);
        end
    endtask

    task automatic test_done();
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // mask reference, field bit i sits at vector bit 31-i
    function automatic logic [31:0] exp_mask(input int mb, input int me);
        logic [31:0] m;
        for (int i = 0; i < 32; i++) begin
            if (mb < me + 1) begin
                m[31-i] = (i >= mb && i <= me);
            end else if (mb == me + 1) begin
                m[31-i] = 1'b1;
            end else begin
                m[31-i] = !(i >= me + 1 && i <= mb - 1);
            end
        end
        return m;
    endfunction

    // one fetch, one execution answer, then compare everything
    task automatic issue(input logic [31:0] w, input ifd_class_t c);
        logic [31:0] a, r, sc;
        logic ov;
        logic [3:0] fp;
        int g;
        a = $urandom & 32'hFFFF_FFFC;
        r = ($urandom_range(3) == 0) ? 32'h0000_0000 : 32'($urandom);
        ov = 1'($urandom_range(1));
        fp = 4'($urandom_range(15));
        @(posedge ref_clk);
        fetch_valid <= 1'b1;
        fetch_word <= w;
        fetch_addr <= a;
        fetch_class <= c;
        res_in <= r;
        ovf_in <= ov;
        fp_in <= fp;
        slow <= 1'($urandom_range(1));
        @(posedge ref_clk);
        fetch_valid <= 1'b0;
        fetch_word <= ~w;
        #1;
        chk("valid", 32'h1, 32'(dec_valid_q));
        chk("opcode", 32'(w[31:26]), 32'(opcode_q));
        repeat (3) @(posedge ref_clk);
        #1;
        if ((c == IFD_CLS_BRANCH || c == IFD_CLS_SYSCALL) && w[0]) m_link = a + 32'h4;
        g = int'(w[25:23]);
        if (c == IFD_CLS_FSTAT_IMM) m_fstat[31-4*g -: 4] = w[15:12];
        if (c == IFD_CLS_EXT_ARITH && w[10]) begin
            m_wrap = ov;
            m_sticky = m_sticky | ov;
        end
        if (w[0] && (c == IFD_CLS_FIXED || c == IFD_CLS_EXT_ARITH)) begin
            m_cond[31:28] = {$signed(r) < 0, $signed(r) > 0, r == 0, m_sticky};
        end
        if (w[0] && c == IFD_CLS_FLOAT) m_cond[27:24] = fp;
        sc = w[1] ? 32'h0000_1FE0 : {19'h0_0000, 1'b1, w[11:5], 5'h00};
        chk("class", 32'(c), 32'(dec_class_q));
        chk("gpr_a", 32'(w[20:16]), 32'(gpr_a_q));
        chk("gpr_b", 32'(w[15:11]), 32'(gpr_b_q));
        chk("count", 32'(w[15:11]), 32'(byte_count_q));
        chk("record", 32'(w[0]), 32'(record_q));
        chk("ovf_en", 32'(w[10]), 32'(ovf_en_q));
        chk("mask", exp_mask(int'(w[10:6]), int'(w[5:1])), rot_mask_q);
        chk("disp", {{6{w[25]}}, w[25:2], 2'h0}, branch_disp_q);
        chk("sc_addr", sc, sc_addr_q);
        chk("link", m_link, link_q);
        chk("fstat", m_fstat, fstat_q);
        chk("cond", m_cond, cond_q);
        chk("wrap", 32'(m_wrap), 32'(wrap_q));
        chk("sticky", 32'(m_sticky), 32'(sticky_q));
    endtask

    // ------------------------------------------------------------
    // clock, watchdog and main sequence
    // ------------------------------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    // about 2040 cycles expected; generous margin before giving up
    initial begin
        repeat (20000) @(posedge ref_clk);
        err_count++;
        test_done();
    end

    initial begin
        logic [31:0] w;
        automatic int pairs [5][2] = '{'{0, 31}, '{31, 30}, '{5, 5}, '{6, 5}, '{20, 3}};
        rst_n = 1'b0;
        fetch_valid = 1'b0;
        fetch_word = 32'h0000_0000;
        fetch_addr = 32'h0000_0000;
        fetch_class = IFD_CLS_OTHER;
        res_in = 32'h0000_0000;
        ovf_in = 1'b0;
        fp_in = 4'h0;
        slow = 1'b0;
        m_link = 32'h0000_0000;
        m_cond = 32'h0000_0000;
        m_fstat = 32'h0000_0000;
        m_wrap = 1'b0;
        m_sticky = 1'b0;
        void'($urandom(26));
        repeat (12) @(posedge ref_clk);
        rst_n <= 1'b1;
        @(posedge ref_clk);
        #1;
        chk("rst_cond", 32'h0000_0000, cond_q);
        chk("rst_mask", 32'h0000_0000, rot_mask_q);
        // mask boundary cases: inside, all ones, wrap-around
        foreach (pairs[k]) begin
            w = $urandom;
            w[10:6] = 5'(pairs[k][0]);
            w[5:1] = 5'(pairs[k][1]);
            issue(w, IFD_CLS_FIXED);
        end
        for (int n = 0; n < 400; n++) begin
            issue(32'($urandom), ifd_class_t'($urandom_range(7)));
        end
        test_done();
    end
endmodule

`default_nettype wire
